// >>> hdl/awc_core.sv
`include "awc_params.svh"
`default_nettype none
// Operation
// RULE1 - Immediate add-with-carry: A gets A plus byte plus carry; carry gets carry-out.
// RULE2 - Short direct immediate form writes sum back to location; 3 bytes, 6 or 8 clocks.
// RULE3 - Register-destination form stores r plus A plus carry in r; 2 bytes, 4 clocks.
// RULE4 - Indexed indirect address is pointer pair plus B; 2 bytes, 8 or 9 clocks.
// RULE5 - Pointer-indirect form reads byte at pointer pair; 1 byte, 4 or 5 clocks.
// RULE6 - Absolute form reads byte at 16-bit address; 3 bytes, 8 or 9 clocks.
// RULE7 - Lower count when fast RAM accessed or no data access.
// RULE8 - Higher count outside fast RAM; immediate-to-accumulator always 4 clocks.
// RULE9 - One counted cycle equals one cpu_clock period.
// RULE10 - Counts apply to code fetched from internal program ROM.
// RULE11 - Plain add immediate: A gets A plus byte, carry-out to carry; 2 bytes, 4 clocks.
// RULE12 - Zero flag on zero result, aux carry on carry out of bit 3.
module awc_core #(
    parameter int FAST_RAM_LO = 16'hfb00,
    parameter int FAST_RAM_HI = 16'hfeff
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  start,
    input  wire logic [3:0]            form,
    input  wire logic                  use_carry,
    input  wire logic [7:0]            imm_byte,
    input  wire logic [15:0]           addr16,
    input  wire logic [7:0]            reg_in,
    input  wire logic [15:0]           pointer_pair,
    input  wire logic [7:0]            reg_b,
    input  wire logic [7:0]            reg_c,
    input  wire logic [7:0]            mem_rdata,
    output logic                       busy,
    output logic                       done,
    output logic [15:0]                mem_addr,
    output logic                       mem_rd,
    output logic                       mem_wr,
    output logic [7:0]                 mem_wdata,
    output logic [7:0]                 acc,
    output logic [7:0]                 reg_out,
    output logic                       reg_we,
    output logic                       carry_flag,
    output logic                       aux_carry_flag,
    output logic                       zero_flag,
    output logic [2:0]                 instr_len,
    output logic [3:0]                 instr_clocks
);
    // Refuse a fast RAM window that a 16-bit address cannot reach
    if (FAST_RAM_LO < 0 || FAST_RAM_LO > FAST_RAM_HI || FAST_RAM_HI > 32'h0000ffff)
    begin : g_bad_window
        $error("fast RAM window invalid");
    end

    awc_pkg::awc_state_t state;
    logic [3:0]  cnt;
    logic [3:0]  cur_form;
    logic        cur_cy;
    logic [7:0]  opnd;
    logic [15:0] ea;
    logic [8:0]  sum;
    logic        half;

    // Effective address per form
    function automatic logic [15:0] eff_addr(input logic [3:0] f, input logic [15:0] a,
                                             input logic [15:0] p, input logic [7:0] b,
                                             input logic [7:0] c, input logic [7:0] i);
        unique case (f)
            4'h1, 4'h4: eff_addr = {8'hfe, i};
            4'h5:       eff_addr = a;
            4'h6:       eff_addr = p;
            4'h7:       eff_addr = p + {8'h00, i};
            4'h8:       eff_addr = p + {8'h00, b}; // RULE4
            4'h9:       eff_addr = p + {8'h00, c};
            default:    eff_addr = 16'h0000;
        endcase
    endfunction : eff_addr

    function automatic logic is_fast(input logic [15:0] a);
        is_fast = ({16'h0000, a} >= FAST_RAM_LO[31:0]) && ({16'h0000, a} <= FAST_RAM_HI[31:0]);
    endfunction : is_fast

    // Second operand byte address for short direct form: low byte of addr16
    logic [15:0] next_ea;
    logic        fast;
    always_comb
    begin
        next_ea = eff_addr(form, addr16, pointer_pair, reg_b, reg_c,
                           (form == 4'h1 || form == 4'h4) ? addr16[7:0] : imm_byte);
        fast = is_fast(next_ea);
    end

    // Lengths and counts; counts hold for internal ROM fetch // RULE10
    always_comb
    begin
        unique case (form)
            4'h0:
            begin
                instr_len    = `AWC_LEN_IMM;
                instr_clocks = `AWC_CLK_IMM; // RULE8
            end
            4'h1:
            begin
                instr_len    = `AWC_LEN_SADDR_IMM; // RULE2
                instr_clocks = fast ? `AWC_CLK_SADDR_IMM_F : `AWC_CLK_SADDR_IMM_S;
            end
            4'h2,
            4'h3:
            begin
                instr_len    = `AWC_LEN_REG;
                instr_clocks = `AWC_CLK_REG; // RULE3
            end
            4'h4:
            begin
                instr_len    = `AWC_LEN_SADDR;
                instr_clocks = fast ? `AWC_CLK_SADDR_F : `AWC_CLK_SADDR_S;
            end
            4'h5:
            begin
                instr_len    = `AWC_LEN_ABS; // RULE6
                instr_clocks = fast ? `AWC_CLK_ABS_F : `AWC_CLK_ABS_S;
            end
            4'h6:
            begin
                instr_len    = `AWC_LEN_PTR; // RULE5
                instr_clocks = fast ? `AWC_CLK_PTR_F : `AWC_CLK_PTR_S; // RULE7
            end
            4'h7,
            4'h8,
            4'h9:
            begin
                instr_len    = `AWC_LEN_PTR_IDX; // RULE4
                instr_clocks = fast ? `AWC_CLK_IDX_F : `AWC_CLK_IDX_S; // RULE8
            end
            default:
            begin
                instr_len    = 3'h0;
                instr_clocks = 4'h0;
            end
        endcase
    end

    // Adder with optional carry in
    always_comb
    begin
        sum  = {1'b0, acc} + {1'b0, opnd} + {8'h00, cur_cy}; // RULE1 RULE11
        half = (({1'b0, acc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cur_cy}) > 5'h0f); // RULE12
    end

    function automatic logic has_mem(input logic [3:0] f);
        has_mem = (f == 4'h1) || (f >= 4'h4 && f <= 4'h9);
    endfunction : has_mem

    // Sequencer: one count per mclk period, which is cpu_clock
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state    <= awc_pkg::AWC_IDLE;
            cnt      <= 4'h0;
            cur_form <= 4'h0;
            cur_cy   <= 1'b0;
            opnd     <= 8'h00;
            ea       <= 16'h0000;
        end
        else
        begin
            unique case (state)
                awc_pkg::AWC_IDLE:
                    if (start && instr_clocks != 4'h0)
                    begin
                        cur_form <= form;
                        cur_cy   <= use_carry & carry_flag;
                        ea       <= next_ea;
                        cnt      <= instr_clocks - 4'h1; // RULE9
                        // Register forms add r to A in either direction
                        opnd     <= (form == 4'h0 || form == 4'h1) ? imm_byte : reg_in;
                        state    <= has_mem(form) ? awc_pkg::AWC_READ : awc_pkg::AWC_WAIT;
                    end
                awc_pkg::AWC_READ:
                begin
                    if (cur_form != 4'h1)
                        opnd <= mem_rdata;
                    cnt   <= cnt - 4'h1;
                    state <= awc_pkg::AWC_WAIT;
                end
                awc_pkg::AWC_WAIT:
                begin
                    cnt <= cnt - 4'h1;
                    if (cnt == 4'h1)
                        state <= awc_pkg::AWC_WRITE;
                end
                awc_pkg::AWC_WRITE:
                    state <= awc_pkg::AWC_IDLE;
            endcase
        end
    end

    // Saddr-immediate operand: location read plus immediate; location held in loc, outside the acc path
    logic [7:0] loc;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            loc <= 8'h00;
        else if (state == awc_pkg::AWC_READ)
            loc <= mem_rdata;
    end

    logic [8:0] sum_loc;
    logic       half_loc;
    always_comb
    begin
        sum_loc  = {1'b0, loc} + {1'b0, opnd} + {8'h00, cur_cy}; // RULE2
        half_loc = (({1'b0, loc[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cur_cy}) > 5'h0f);
    end

    // Result write-back and flags
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            acc            <= `AWC_RST_ACC;
            reg_out        <= 8'h00;
            reg_we         <= 1'b0;
            mem_wr         <= 1'b0;
            mem_wdata      <= 8'h00;
            carry_flag     <= 1'b0;
            aux_carry_flag <= 1'b0;
            zero_flag      <= 1'b0;
            done           <= 1'b0;
        end
        else
        begin
            reg_we <= 1'b0;
            mem_wr <= 1'b0;
            done   <= 1'b0;
            if (state == awc_pkg::AWC_WRITE)
            begin
                done <= 1'b1;
                if (cur_form == 4'h1)
                begin
                    mem_wr         <= 1'b1;
                    mem_wdata      <= sum_loc[7:0];
                    carry_flag     <= sum_loc[8];
                    aux_carry_flag <= half_loc;
                    zero_flag      <= (sum_loc[7:0] == 8'h00); // RULE12
                end
                else
                begin
                    if (cur_form == 4'h3)
                    begin
                        reg_out <= sum[7:0]; // RULE3
                        reg_we  <= 1'b1;
                    end
                    else
                        acc <= sum[7:0]; // RULE1
                    carry_flag     <= sum[8];
                    aux_carry_flag <= half;
                    zero_flag      <= (sum[7:0] == 8'h00); // RULE12
                end
            end
        end
    end

    assign busy     = (state != awc_pkg::AWC_IDLE);
    assign mem_rd   = (state == awc_pkg::AWC_READ);
    assign mem_addr = ea;
endmodule : awc_core
`default_nettype wire

// >>> hdl/awc_params.svh
`ifndef AWC_PARAMS_SVH
`define AWC_PARAMS_SVH
// Instruction lengths in bytes
`define AWC_LEN_IMM        3'h2
`define AWC_LEN_SADDR_IMM  3'h3
`define AWC_LEN_REG        3'h2
`define AWC_LEN_SADDR      3'h2
`define AWC_LEN_ABS        3'h3
`define AWC_LEN_PTR        3'h1
`define AWC_LEN_PTR_IDX    3'h2
// Clock counts: fast RAM or no data access / other area
`define AWC_CLK_IMM        4'h4
`define AWC_CLK_REG        4'h4
`define AWC_CLK_SADDR_IMM_F 4'h6
`define AWC_CLK_SADDR_IMM_S 4'h8
`define AWC_CLK_SADDR_F    4'h4
`define AWC_CLK_SADDR_S    4'h5
`define AWC_CLK_ABS_F      4'h8
`define AWC_CLK_ABS_S      4'h9
`define AWC_CLK_PTR_F      4'h4
`define AWC_CLK_PTR_S      4'h5
`define AWC_CLK_IDX_F      4'h8
`define AWC_CLK_IDX_S      4'h9
// Accumulator and flag reset values
`define AWC_RST_ACC        8'h00
`define AWC_RST_FLAGS      3'h0
`endif

// >>> hdl/awc_pkg.sv
`default_nettype none
package awc_pkg;
    // Operand forms
    typedef enum logic [3:0] {
        AWC_FORM_IMM       = 4'h0,  // A, #byte
        AWC_FORM_SADDR_IMM = 4'h1,  // saddr, #byte
        AWC_FORM_A_REG     = 4'h2,  // A, r
        AWC_FORM_REG_A     = 4'h3,  // r, A
        AWC_FORM_SADDR     = 4'h4,  // A, saddr
        AWC_FORM_ABS       = 4'h5,  // A, !addr16
        AWC_FORM_PTR       = 4'h6,  // A, [pointer]
        AWC_FORM_PTR_BYTE  = 4'h7,  // A, [pointer + byte]
        AWC_FORM_PTR_B     = 4'h8,  // A, [pointer + B]
        AWC_FORM_PTR_C     = 4'h9   // A, [pointer + C]
    } awc_form_t;

    typedef enum logic [1:0] {
        AWC_IDLE  = 2'b00,
        AWC_READ  = 2'b01,
        AWC_WAIT  = 2'b10,
        AWC_WRITE = 2'b11
    } awc_state_t;
endpackage : awc_pkg
`default_nettype wire

// >>> verification/add_with_carry_ops_test.sv
`default_nettype none
module add_with_carry_ops_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, busy, done, mem_rd, mem_wr, reg_we, carry_flag, aux_carry_flag, zero_flag;
    logic        rst = 1'b1, start = 1'b0, use_carry = 1'b0;
    logic [3:0]  form = 4'h0;
    logic [7:0]  imm_byte = 8'h00, reg_in = 8'h00, reg_b = 8'h00, reg_c = 8'h00;
    logic [15:0] addr16 = 16'h0000, pointer_pair = 16'h0000, mem_addr;
    logic [7:0]  mem_rdata, mem_wdata, acc, reg_out, m_acc = 8'h00;
    logic [2:0]  instr_len;
    logic [3:0]  instr_clocks;
    logic        m_cy = 1'b0;
    int          err_total = 0, tests_run = 0, cyc = 0;
    awc_core awc_core_inst (
        .mclk           (mclk),
        .rst            (rst),
        .start          (start),
        .form           (form),
        .use_carry      (use_carry),
        .imm_byte       (imm_byte),
        .addr16         (addr16),
        .reg_in         (reg_in),
        .pointer_pair   (pointer_pair),
        .reg_b          (reg_b),
        .reg_c          (reg_c),
        .mem_rdata      (mem_rdata),
        .busy           (busy),
        .done           (done),
        .mem_addr       (mem_addr),
        .mem_rd         (mem_rd),
        .mem_wr         (mem_wr),
        .mem_wdata      (mem_wdata),
        .acc            (acc),
        .reg_out        (reg_out),
        .reg_we         (reg_we),
        .carry_flag     (carry_flag),
        .aux_carry_flag (aux_carry_flag),
        .zero_flag      (zero_flag),
        .instr_len      (instr_len),
        .instr_clocks   (instr_clocks)
    );
    awc_mem awc_mem_inst (
        .mclk      (mclk),
        .mem_addr  (mem_addr),
        .mem_rd    (mem_rd),
        .mem_wr    (mem_wr),
        .mem_wdata (mem_wdata),
        .mem_rdata (mem_rdata)
    );
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction : pat
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input logic [3:0] f, input logic uc, input logic [7:0] opnd,
                       input logic [3:0] exp_n, input logic [2:0] exp_len);
        logic [7:0] base;
        logic [8:0] sum;
        logic       cin, h;
        int         n;
        base = f == 4'h3 ? reg_in : f == 4'h1 ? awc_mem_inst.mem[{8'hfe, addr16[7:0]}] : m_acc;
        cin = uc & m_cy;
        sum = 9'(base) + 9'(opnd) + 9'(cin);
        h = 5'(base[3:0]) + 5'(opnd[3:0]) + 5'(cin) > 5'h0f;
        @(posedge mclk);
        #1 form = f;
        use_carry = uc;
        start = 1'b1;
        @(posedge mclk);
        chk(16'(instr_clocks), 16'(exp_n));
        chk(16'(instr_len), 16'(exp_len));
        #1 start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 12)
        begin
            @(posedge mclk);
            #1 n++;
        end
        chk(16'(n), 16'(exp_n));
        chk(16'(reg_we), 16'(f == 4'h3));
        chk(16'(mem_wr), 16'(f == 4'h1));
        @(posedge mclk);
        #1;
        if (f == 4'h1)
            chk(16'(awc_mem_inst.mem[{8'hfe, addr16[7:0]}]), 16'(sum[7:0]));
        else if (f == 4'h3)
            chk(16'(reg_out), 16'(sum[7:0]));
        else
            m_acc = sum[7:0];
        chk(16'(acc), 16'(m_acc));
        chk({13'h0, carry_flag, aux_carry_flag, zero_flag}, {13'h0, sum[8], h, !(|sum[7:0])});
        m_cy = sum[8];
    endtask : run
    task automatic t_immediate;
        imm_byte = 8'h8f;
        run(4'h0, 1'b0, imm_byte, 4'h4, 3'h2);
        imm_byte = 8'h71;
        run(4'h0, 1'b1, imm_byte, 4'h4, 3'h2);
        imm_byte = 8'h00;
        run(4'h0, 1'b1, imm_byte, 4'h4, 3'h2);
    endtask : t_immediate
    task automatic t_reg_dest;
        reg_in = 8'hff;
        run(4'h3, 1'b1, m_acc, 4'h4, 3'h2);
    endtask : t_reg_dest
    task automatic t_pointer;
        pointer_pair = 16'hfb10;
        run(4'h6, 1'b1, pat(pointer_pair), 4'h4, 3'h1);
        pointer_pair = 16'h1234;
        run(4'h6, 1'b1, pat(pointer_pair), 4'h5, 3'h1);
    endtask : t_pointer
    task automatic t_indexed;
        pointer_pair = 16'hfef0;
        reg_b = 8'h20;
        run(4'h8, 1'b1, pat(16'hff10), 4'h9, 3'h2);
        pointer_pair = 16'hfe00;
        reg_b = 8'h05;
        run(4'h8, 1'b0, pat(16'hfe05), 4'h8, 3'h2);
    endtask : t_indexed
    task automatic t_absolute;
        addr16 = 16'hfc00;
        run(4'h5, 1'b1, pat(addr16), 4'h8, 3'h3);
        addr16 = 16'h8000;
        run(4'h5, 1'b1, pat(addr16), 4'h9, 3'h3);
    endtask : t_absolute
    task automatic t_saddr_imm;
        addr16 = 16'h1240;
        imm_byte = 8'hc3;
        run(4'h1, 1'b1, imm_byte, 4'h6, 3'h3);
    endtask : t_saddr_imm
    task automatic t_other_forms;
        reg_in = 8'h3c;
        run(4'h2, 1'b1, reg_in, 4'h4, 3'h2);
        addr16 = 16'h00a5;
        run(4'h4, 1'b1, pat(16'hfea5), 4'h4, 3'h2);
        pointer_pair = 16'hfef8;
        imm_byte = 8'h10;
        run(4'h7, 1'b1, pat(16'hff08), 4'h9, 3'h2);
        pointer_pair = 16'hfd00;
        reg_c = 8'h04;
        run(4'h9, 1'b0, pat(16'hfd04), 4'h8, 3'h2);
    endtask : t_other_forms
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // Cuts a hang short well past the expected run length
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        #1 rst = 1'b0;
        t_immediate();
        t_reg_dest();
        t_pointer();
        t_indexed();
        t_absolute();
        t_saddr_imm();
        t_other_forms();
        tally_and_finish();
    end
endmodule : add_with_carry_ops_test
bind awc_core awc_core_asserts #(
    .FAST_RAM_LO (FAST_RAM_LO),
    .FAST_RAM_HI (FAST_RAM_HI)
) awc_core_asserts_inst (
    .mclk         (mclk),
    .rst          (rst),
    .start        (start),
    .form         (form),
    .addr16       (addr16),
    .pointer_pair (pointer_pair),
    .reg_b        (reg_b),
    .busy         (busy),
    .done         (done),
    .mem_addr     (mem_addr),
    .mem_rd       (mem_rd),
    .mem_wr       (mem_wr),
    .acc          (acc),
    .reg_we       (reg_we),
    .zero_flag    (zero_flag),
    .instr_len    (instr_len),
    .instr_clocks (instr_clocks)
);
`default_nettype wire

// >>> verification/awc_core_asserts.sv
`default_nettype none
module awc_core_asserts #(
    parameter int FAST_RAM_LO = 16'hfb00,
    parameter int FAST_RAM_HI = 16'hfeff
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        start,
    input wire logic [3:0]  form,
    input wire logic [15:0] addr16,
    input wire logic [15:0] pointer_pair,
    input wire logic [7:0]  reg_b,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  acc,
    input wire logic        reg_we,
    input wire logic        zero_flag,
    input wire logic [2:0]  instr_len,
    input wire logic [3:0]  instr_clocks
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       run;
    logic [3:0] cnt;
    logic [3:0] need;
    function automatic logic fast(input logic [15:0] a);
        return a >= FAST_RAM_LO && a <= FAST_RAM_HI;
    endfunction : fast
    // Counts cycles since an accepted start
    always_ff @(posedge mclk or posedge rst)
        if (rst)
        begin
            run  <= 1'b0;
            cnt  <= 4'h0;
            need <= 4'h0;
        end
        else if (start && !busy && form <= 4'h9)
        begin
            run  <= 1'b1;
            cnt  <= 4'h0;
            need <= instr_clocks;
        end
        else if (run)
        begin
            run <= !done;
            cnt <= cnt + 4'h1;
        end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_done_on_count: assert property (run && cnt == need |-> done)
        else $error("done missing at the counted cycle");
    a_done_not_early: assert property (done |-> run && cnt == need)
        else $error("done outside the counted cycle");
    a_imm_timing: assert property (form == 4'h0 |-> instr_clocks == 4'h4 && instr_len == 3'h2)
        else $error("immediate form timing wrong");
    a_saddr_timing: assert property (form == 4'h1 |-> instr_len == 3'h3 && instr_clocks ==
        (fast({8'hfe, addr16[7:0]}) ? 4'h6 : 4'h8)) else $error("short direct form timing wrong");
    a_abs_timing: assert property (form == 4'h5 |-> instr_len == 3'h3 &&
        instr_clocks == (fast(addr16) ? 4'h8 : 4'h9)) else $error("absolute form timing wrong");
    a_ptr_timing: assert property (form == 4'h6 |-> instr_len == 3'h1 &&
        instr_clocks == (fast(pointer_pair) ? 4'h4 : 4'h5)) else $error("pointer form timing wrong");
    a_idx_timing: assert property (form == 4'h8 |-> instr_len == 3'h2 &&
        instr_clocks == (fast(pointer_pair + 16'(reg_b)) ? 4'h8 : 4'h9))
        else $error("indexed form timing wrong");
    a_idx_address: assert property (start && !busy && form == 4'h8 |=> mem_rd &&
        mem_addr == $past(pointer_pair) + 16'($past(reg_b))) else $error("indexed address wrong");
    a_write_with_done: assert property (mem_wr |-> done)
        else $error("memory write outside done");
    a_zero_acc: assert property (done && !reg_we && !mem_wr |=> zero_flag == (acc == 8'h00))
        else $error("zero flag disagrees with accumulator");
    c_slow_abs: cover property (start && !busy && form == 4'h5 && instr_clocks == 4'h9);
    c_mem_write: cover property (mem_wr);
    c_reg_write: cover property (reg_we);
endmodule : awc_core_asserts
`default_nettype wire

// >>> verification/awc_mem.sv
`default_nettype none
module awc_mem (
    input  wire logic        mclk,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic [7:0]  mem_wdata,
    output logic [7:0]       mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535];
    logic [7:0] last;
    initial
    begin
        last = 8'h00;
        for (int i = 0; i < 65536; i++)
            mem[i] = 8'(i ^ (i >> 8)) ^ 8'h5a;
    end
    // Off-read cycles show the inverse of the last byte, never a stale copy
    assign mem_rdata = mem_rd ? mem[mem_addr] : ~last;
    always @(posedge mclk)
    begin
        if (mem_rd)
            last <= mem[mem_addr];
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
    end
endmodule : awc_mem
`default_nettype wire
